// ---- verilog/lbt_pkg.sv ----
// Constants and types for the local bus strobe timing block
// Assumes byte offsets from the PCI target config decoder
package lbt_pkg;
   // Register offsets
   localparam logic [7:0] OFS_T1 = 8'h08;
   localparam logic [7:0] OFS_T2 = 8'h0C;
   // Timing register one, low bit of each field
   localparam int T1_WCS_OFF = 12;
   localparam int T1_RD_ON   = 16;
   localparam int T1_RD_OFF  = 20;
   localparam int T1_WR_ON   = 24;
   localparam int T1_WR_OFF  = 28;
   // Timing register two, low bit of each field
   localparam int T2_WD_ON   = 0;
   localparam int T2_WD_OFF  = 4;
   localparam int T2_RD_DRV  = 8;
   localparam int T2_RD_HIZ  = 12;
   localparam int T2_IOSZ    = 20;
   localparam int T2_CSLOW   = 23;
   localparam int T2_DSTYPE  = 31;
   // Writable bits of timing register two
   localparam logic [31:0] T2_RW_MASK = 32'h8780_FFFF;
   // Reset values, normal and parallel port
   localparam logic [31:0] T1_RST    = 32'h2030_2030;
   localparam logic [31:0] T1_RST_PP = 32'h2121_2020;
   localparam logic [31:0] T2_RST    = 32'h00C0_04F0;
   localparam logic [31:0] T2_RST_PP = 32'h0120_02F0;
   // Timing limits
   localparam logic [3:0] MAX_CNT  = 4'hA;
   localparam logic [3:0] KEEP_DRV = 4'hF;
   localparam int         REF_DELAY = 2;
   localparam int         CS_BASE8  = 2;
   localparam int         CS_BASE32 = 4;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_RUN  = 3'b100
   } lbt_state_t;
endpackage

// ---- verilog/lbt_strobe_timing.sv ----
// Local bus cycle timing generator behind a PCI target function
// Assumes txn_start marks the first IRDY# cycle of a local bus access
//
// Contract
// RQ1: Reference cycle is second clock after IRDY#
// RQ2: Bit 31 selects separate or data strobes
// RQ3: Separate mode: chip select rises at 15:12; code does so for writes only, reads raise it at 23:20
// RQ4: Strobe mode: read-not-write rises at 15:12
// RQ5: Separate mode: read strobe falls at 19:16
// RQ6: Strobe mode: read data strobes fall 19:16
// RQ7: Separate mode: read strobe rises at 23:20
// RQ8: Strobe mode: read data strobes rise 23:20
// RQ9: Separate mode: write strobe falls at 27:24
// RQ10: Strobe mode: write data strobes fall 27:24
// RQ11: Separate mode: write strobe rises at 31:28
// RQ12: Strobe mode: write data strobes rise 31:28
// RQ13: Software keeps timing fields within 0 to Ah
// RQ14: Out-of-range field retries every access
// RQ15: Same timing for 8-bit and 32-bit buses
// RQ16: Write data drive starts at 3:0
// RQ17: Write data release at 7:4
// RQ18: Release not Fh: high impedance outside writes
// RQ19: Read end: data drive resumes at 11:8
// RQ20: Read start: data released at 15:12
// RQ21: IO block size field, read-only
// RQ22: Chip select decode low bit from 26:23
// RQ23: Count clocks, toggle on match, then complete
`timescale 1ns/1ps
module lbt_strobe_timing #(
   parameter int DATA_W = 8
) (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              reset,
   // Parallel port strap
   input  wire logic              par_port_strap,
   // Configuration register port
   input  wire logic              reg_write,
   input  wire logic              reg_read,
   input  wire logic [7:0]        reg_offset,
   input  wire logic [3:0]        reg_byte_en,
   input  wire logic [31:0]       reg_wdata,
   output logic      [31:0]       reg_rdata,
   output logic      [2:0]        bar0_size_code,
   // PCI target transfer side
   input  wire logic              txn_start,
   input  wire logic              txn_write,
   input  wire logic [15:0]       txn_addr,
   input  wire logic [3:0]        txn_byte_en,
   input  wire logic [DATA_W-1:0] txn_wdata,
   output logic      [DATA_W-1:0] txn_rdata,
   output logic                   txn_done,
   output logic                   txn_retry,
   // Local bus
   output logic      [15:0]       periph_addr,
   output logic      [3:0]        periph_chip_selects_n,
   output logic                   periph_read_not_write_n,
   output logic                   periph_read_strobe_n,
   output logic                   periph_write_strobe_n,
   output logic      [3:0]        periph_data_strobes_n,
   input  wire logic [DATA_W-1:0] periph_data_in,
   output logic      [DATA_W-1:0] periph_data_out,
   output logic                   periph_data_oe
);
   if (DATA_W != 8 && DATA_W != 32) begin : g_bad_width
      $error("DATA_W must be 8 or 32");
   end

   logic [31:0]        local_bus_timing_one;
   logic [31:0]        local_bus_timing_two;
   logic [31:0]        s1;
   logic [31:0]        s2;
   logic               pp_mode;
   lbt_pkg::lbt_state_t state;
   logic [3:0]         count;
   logic [3:0]         cur_last;
   logic               cur_wr;
   logic               cur_ds;
   logic [3:0]         cur_cs;
   logic [3:0]         cur_be;
   logic [31:0]        t2_mask;
   logic [4:0]         cs_shift;
   logic [15:0]        cs_addr;
   logic               start_ok;
   logic               ev_on;
   logic [3:0]         upc;
   logic [3:0]         f_wcs, f_on, f_off;
   logic [3:0]         f_wdon, f_wdoff, f_rdrv, f_rhiz;

   function automatic logic [3:0] mx(logic [3:0] a, logic [3:0] b);
      return (a > b) ? a : b;
   endfunction

   // Field range check; release may also hold Fh
   function automatic logic cfg_ok(logic [31:0] t1, logic [31:0] t2);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 8; i++) begin
         if (t1[4*i +: 4] > lbt_pkg::MAX_CNT) ok = 1'b0;
      end
      for (int i = 0; i < 4; i++) begin
         if (t2[4*i +: 4] > lbt_pkg::MAX_CNT &&
             !(i == 1 && t2[4*i +: 4] == lbt_pkg::KEEP_DRV)) ok = 1'b0;
      end
      return ok;
   endfunction

   // Latest programmed event of a cycle
   function automatic logic [3:0] last_ev(logic [31:0] t1, logic [31:0] t2,
                                          logic wr);
      logic [3:0] m;
      m = 4'h0;
      if (wr) begin
         m = mx(mx(t1[lbt_pkg::T1_WCS_OFF +: 4], t1[lbt_pkg::T1_WR_ON +: 4]),
                t1[lbt_pkg::T1_WR_OFF +: 4]);
         m = mx(m, t2[lbt_pkg::T2_WD_ON +: 4]);
         if (t2[lbt_pkg::T2_WD_OFF +: 4] != lbt_pkg::KEEP_DRV) begin
            m = mx(m, t2[lbt_pkg::T2_WD_OFF +: 4]);
         end
      end else begin
         m = mx(t1[lbt_pkg::T1_RD_ON +: 4], t1[lbt_pkg::T1_RD_OFF +: 4]);
         if (t2[lbt_pkg::T2_WD_OFF +: 4] == lbt_pkg::KEEP_DRV) begin
            m = mx(m, mx(t2[lbt_pkg::T2_RD_DRV +: 4], t2[lbt_pkg::T2_RD_HIZ +: 4]));
         end
      end
      return m;
   endfunction

   assign start_ok = cfg_ok(local_bus_timing_one, local_bus_timing_two);
   assign t2_mask  = pp_mode ? (lbt_pkg::T2_RW_MASK & 32'h7FFF_FFFF) : lbt_pkg::T2_RW_MASK;
   assign cs_shift = 5'((DATA_W == 32) ? lbt_pkg::CS_BASE32 : lbt_pkg::CS_BASE8) +
                     5'(local_bus_timing_two[lbt_pkg::T2_CSLOW +: 4]); // RQ22
   assign cs_addr  = txn_addr >> cs_shift;
   assign bar0_size_code = local_bus_timing_two[lbt_pkg::T2_IOSZ +: 3]; // RQ21

   // Snapshot fields used during a cycle
   assign f_wcs   = s1[lbt_pkg::T1_WCS_OFF +: 4];
   assign f_on    = cur_wr ? s1[lbt_pkg::T1_WR_ON +: 4] : s1[lbt_pkg::T1_RD_ON +: 4];
   assign f_off   = cur_wr ? s1[lbt_pkg::T1_WR_OFF +: 4] : s1[lbt_pkg::T1_RD_OFF +: 4];
   assign f_wdon  = s2[lbt_pkg::T2_WD_ON +: 4];
   assign f_wdoff = s2[lbt_pkg::T2_WD_OFF +: 4];
   assign f_rdrv  = s2[lbt_pkg::T2_RD_DRV +: 4];
   assign f_rhiz  = s2[lbt_pkg::T2_RD_HIZ +: 4];

   // Count that the pins show after the coming edge
   assign ev_on = (state == lbt_pkg::ST_WAIT) ||
                  (state == lbt_pkg::ST_RUN && count != cur_last);
   assign upc   = (state == lbt_pkg::ST_WAIT) ? 4'h0 : 4'(count + 4'h1);

   // Strap caught while reset is held
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pp_mode <= par_port_strap;
      end
   end

   // Timing registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         local_bus_timing_one <= par_port_strap ? lbt_pkg::T1_RST_PP : lbt_pkg::T1_RST;
         local_bus_timing_two <= par_port_strap ? lbt_pkg::T2_RST_PP : lbt_pkg::T2_RST;
      end else if (reg_write) begin
         for (int b = 0; b < 4; b++) begin
            if (reg_byte_en[b] && reg_offset == lbt_pkg::OFS_T1) begin
               local_bus_timing_one[8*b +: 8] <= reg_wdata[8*b +: 8];
            end
            if (reg_byte_en[b] && reg_offset == lbt_pkg::OFS_T2) begin
               local_bus_timing_two[8*b +: 8] <=
                  (reg_wdata[8*b +: 8] & t2_mask[8*b +: 8]) |
                  (local_bus_timing_two[8*b +: 8] & ~t2_mask[8*b +: 8]); // RQ21
            end
         end
      end
   end

   // Register read data, unmapped offsets read zero
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_read) begin
         reg_rdata <= (reg_offset == lbt_pkg::OFS_T1) ? local_bus_timing_one :
                      (reg_offset == lbt_pkg::OFS_T2) ? local_bus_timing_two :
                      32'h0000_0000;
      end
   end

   // Sequencer and per-cycle snapshot
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state    <= lbt_pkg::ST_IDLE;
         count    <= 4'h0;
         cur_last <= 4'h0;
         cur_wr   <= 1'b0;
         cur_ds   <= 1'b0;
         cur_cs   <= 4'h0;
         cur_be   <= 4'h0;
         s1       <= lbt_pkg::T1_RST;
         s2       <= lbt_pkg::T2_RST;
         periph_addr     <= 16'h0000;
         periph_data_out <= '0;
      end else begin
         unique case (state)
            lbt_pkg::ST_IDLE: begin
               if (txn_start && start_ok) begin // RQ14
                  state    <= lbt_pkg::ST_WAIT; // RQ1
                  count    <= 4'h0;
                  cur_last <= last_ev(local_bus_timing_one, local_bus_timing_two,
                                      txn_write); // RQ23
                  cur_wr   <= txn_write;
                  cur_ds   <= local_bus_timing_two[lbt_pkg::T2_DSTYPE]; // RQ2
                  cur_cs   <= 4'b0001 << cs_addr[1:0]; // RQ22
                  cur_be   <= txn_byte_en;
                  s1       <= local_bus_timing_one;
                  s2       <= local_bus_timing_two;
                  periph_addr     <= txn_addr;
                  periph_data_out <= txn_wdata; // RQ15
               end
            end
            lbt_pkg::ST_WAIT: begin
               if (count == 4'(lbt_pkg::REF_DELAY - 2)) begin
                  state <= lbt_pkg::ST_RUN; // RQ1
                  count <= 4'h0;
               end else begin
                  count <= 4'(count + 4'h1);
               end
            end
            lbt_pkg::ST_RUN: begin
               if (count == cur_last) begin
                  state <= lbt_pkg::ST_IDLE; // RQ23
               end else begin
                  count <= 4'(count + 4'h1);
               end
            end
         endcase
      end
   end

   // Completion, retry and read data capture
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         txn_done  <= 1'b0;
         txn_retry <= 1'b0;
         txn_rdata <= '0;
      end else begin
         txn_done  <= (state == lbt_pkg::ST_RUN) && (count == cur_last); // RQ23
         txn_retry <= (state == lbt_pkg::ST_IDLE) && txn_start && !start_ok; // RQ14
         if (ev_on && !cur_wr && upc == f_off) begin
            txn_rdata <= periph_data_in;
         end
      end
   end

   // Chip selects
   always_ff @(posedge clk_sys) begin
      if (reset || !ev_on) begin
         periph_chip_selects_n <= 4'hF;
      end else begin
         if (upc == 4'h0) periph_chip_selects_n <= ~cur_cs;
         if (!cur_ds && upc == (cur_wr ? f_wcs : f_off)) begin
            periph_chip_selects_n <= 4'hF; // RQ3
         end
      end
   end

   // Read-not-write line
   always_ff @(posedge clk_sys) begin
      if (reset || !ev_on || !cur_ds || !cur_wr) begin
         periph_read_not_write_n <= 1'b1;
      end else begin
         if (upc == 4'h0) periph_read_not_write_n <= 1'b0;
         if (upc == f_wcs) periph_read_not_write_n <= 1'b1; // RQ4
      end
   end

   // Separate strobes and data strobes
   always_ff @(posedge clk_sys) begin
      if (reset || !ev_on) begin
         periph_read_strobe_n  <= 1'b1;
         periph_write_strobe_n <= 1'b1;
         periph_data_strobes_n <= 4'hF;
      end else begin
         if (upc == f_on) begin
            if (cur_ds) periph_data_strobes_n <= ~cur_be; // RQ6 RQ10
            else if (cur_wr) periph_write_strobe_n <= 1'b0; // RQ9
            else periph_read_strobe_n <= 1'b0; // RQ5
         end
         if (upc == f_off) begin
            periph_data_strobes_n <= 4'hF; // RQ8 RQ12
            periph_write_strobe_n <= 1'b1; // RQ11
            periph_read_strobe_n  <= 1'b1; // RQ7
         end
      end
   end

   // Data pin drive enable
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         periph_data_oe <= 1'b0;
      end else if (!ev_on) begin
         periph_data_oe <= (local_bus_timing_two[lbt_pkg::T2_WD_OFF +: 4] ==
                            lbt_pkg::KEEP_DRV); // RQ18
      end else if (cur_wr) begin
         if (upc == f_wdon) periph_data_oe <= 1'b1; // RQ16
         if (upc == f_wdoff) periph_data_oe <= 1'b0; // RQ17
      end else if (f_wdoff == lbt_pkg::KEEP_DRV) begin
         if (upc == f_rdrv) periph_data_oe <= 1'b1; // RQ19
         if (upc == f_rhiz) periph_data_oe <= 1'b0; // RQ20
      end else begin
         periph_data_oe <= 1'b0; // RQ18
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   logic run_n;
   assign run_n = (state == lbt_pkg::ST_RUN) && (count != cur_last) && !cur_wr;

   sequence s_take;
      state == lbt_pkg::ST_IDLE && txn_start && start_ok;
   endsequence
   sequence s_ref;
      state == lbt_pkg::ST_RUN && count == 4'h0;
   endsequence

   a_ref_two_clocks: assert property (s_take |-> ##2 s_ref) // RQ1
      else $error("reference cycle not two clocks after start");
   a_mode_select: assert property (s_take |=> cur_ds == $past(local_bus_timing_two[31])) // RQ2
      else $error("interface type not taken from bit 31");
   a_cs_write_rise: assert property (state == lbt_pkg::ST_RUN && cur_wr && !cur_ds &&
      count == f_wcs |-> periph_chip_selects_n == 4'hF) // RQ3
      else $error("chip select not released on write count");
   a_rnw_rise: assert property (state == lbt_pkg::ST_RUN && cur_wr && cur_ds &&
      count == f_wcs |-> periph_read_not_write_n) // RQ4
      else $error("read-not-write not released on count");
   a_rd_fall: assert property (run_n && !cur_ds && count == f_on && f_on < f_off
      |-> !periph_read_strobe_n) // RQ5
      else $error("read strobe not low on count");
   a_ds_rd_fall: assert property (run_n && cur_ds && count == f_on && f_on < f_off
      |-> periph_data_strobes_n == ~cur_be) // RQ6
      else $error("read data strobes not low on count");
   a_rd_rise: assert property (run_n && count == f_off |-> periph_read_strobe_n &&
      periph_data_strobes_n == 4'hF) // RQ7
      else $error("read strobes not high on count");
   a_wr_pulse: assert property (state == lbt_pkg::ST_RUN && cur_wr && !cur_ds &&
      count == f_on && f_on < f_off |-> !periph_write_strobe_n) // RQ9
      else $error("write strobe not low on count");
   a_wr_rise: assert property (state == lbt_pkg::ST_RUN && cur_wr &&
      count == f_off |-> periph_write_strobe_n && periph_data_strobes_n == 4'hF) // RQ11
      else $error("write strobes not high on count");
   a_retry_bad: assert property (state == lbt_pkg::ST_IDLE && txn_start && !start_ok
      |=> txn_retry && state == lbt_pkg::ST_IDLE) // RQ14
      else $error("bad timing field did not retry");
   a_wd_drive: assert property (state == lbt_pkg::ST_RUN && cur_wr && count == f_wdon &&
      f_wdon < f_wdoff |-> periph_data_oe) // RQ16
      else $error("write data not driven on count");
   a_wd_release: assert property (state == lbt_pkg::ST_RUN && cur_wr &&
      count == f_wdoff |-> !periph_data_oe) // RQ17
      else $error("write data not released on count");
   a_idle_hiz: assert property (state == lbt_pkg::ST_IDLE && $past(state) ==
      lbt_pkg::ST_IDLE && $past(local_bus_timing_two[7:4]) != 4'hF
      |-> !periph_data_oe) // RQ18
      else $error("data driven outside write");
   a_size_ro: assert property (reg_write |=> $stable(bar0_size_code)) // RQ21
      else $error("block size field changed by write");
   a_done_last: assert property (state == lbt_pkg::ST_RUN && count == cur_last
      |=> txn_done ##1 !txn_done) // RQ23
      else $error("done not one pulse after last event");
endmodule // lbt_strobe_timing

// ---- tb/lbt_periph_model.sv ----
// Peripheral on the local bus: answers reads with a word set by the bench
// Assumes active-low strobes from the timing block; resolves the data wire
`timescale 1ns/1ps
module lbt_periph_model #(
   parameter int DATA_W = 8
) (
   // Strobes from the timing block
   input  wire logic              read_strobe_n,
   input  wire logic              read_not_write_n,
   input  wire logic [3:0]        data_strobes_n,
   // Data wire parties
   input  wire logic              data_oe,
   input  wire logic [DATA_W-1:0] data_out,
   input  wire logic [DATA_W-1:0] read_word,
   output logic      [DATA_W-1:0] data_in
);
   logic              drive;
   logic [DATA_W-1:0] last = '0;
   // Drives only while its read is strobed
   assign drive = !read_strobe_n || (data_strobes_n != 4'hF && read_not_write_n);
   always @(drive or read_word) begin
      if (drive) begin
         last = read_word;
      end
   end
   // Released wire shows the inverse of the last value
   assign data_in = data_oe ? data_out : (drive ? read_word : ~last);
endmodule // lbt_periph_model

// ---- tb/test_local_bus_strobe_timing.sv ----
// Self-checking bench for the local bus strobe timing block
// Assumes lbt_pkg, lbt_strobe_timing and lbt_periph_model are compiled first
`timescale 1ns/1ps
module test_local_bus_strobe_timing;
   logic        clk_sys        = 1'b0;
   logic        reset          = 1'b1;
   logic        par_port_strap = 1'b0;
   logic        reg_write      = 1'b0;
   logic        reg_read       = 1'b0;
   logic [7:0]  reg_offset     = 8'h00;
   logic [3:0]  reg_byte_en    = 4'h0;
   logic [31:0] reg_wdata      = 32'h0000_0000;
   logic        txn_start      = 1'b0;
   logic        txn_write      = 1'b0;
   logic [15:0] txn_addr       = 16'h0000;
   logic [3:0]  txn_byte_en    = 4'h0;
   logic [7:0]  txn_wdata      = 8'h00;
   logic [7:0]  read_word      = 8'h5A;
   logic [31:0] reg_rdata;
   logic [2:0]  bar0_size_code;
   logic [7:0]  txn_rdata;
   logic        txn_done;
   logic        txn_retry;
   logic [15:0] periph_addr;
   logic [3:0]  periph_chip_selects_n;
   logic        periph_read_not_write_n;
   logic        periph_read_strobe_n;
   logic        periph_write_strobe_n;
   logic [3:0]  periph_data_strobes_n;
   logic [7:0]  periph_data_in;
   logic [7:0]  periph_data_out;
   logic        periph_data_oe;
   logic [31:0] tr [8];
   logic [3:0]  cs_at2;
   logic [3:0]  ds_at2;
   int          error_cnt   = 0;
   int          comparisons = 0;
   int          cycles      = 0;

   lbt_strobe_timing #(.DATA_W(8)) i_lbt_strobe_timing (.clk_sys, .reset, .par_port_strap,
      .reg_write, .reg_read, .reg_offset, .reg_byte_en, .reg_wdata, .reg_rdata,
      .bar0_size_code, .txn_start, .txn_write, .txn_addr, .txn_byte_en, .txn_wdata,
      .txn_rdata, .txn_done, .txn_retry, .periph_addr, .periph_chip_selects_n,
      .periph_read_not_write_n, .periph_read_strobe_n, .periph_write_strobe_n,
      .periph_data_strobes_n, .periph_data_in, .periph_data_out, .periph_data_oe);

   lbt_periph_model #(.DATA_W(8)) i_lbt_periph_model (.read_strobe_n(periph_read_strobe_n),
      .read_not_write_n(periph_read_not_write_n), .data_strobes_n(periph_data_strobes_n),
      .data_oe(periph_data_oe), .data_out(periph_data_out), .read_word(read_word),
      .data_in(periph_data_in));

   initial begin
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic end_of_test();
      $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         error_cnt++;
         end_of_test();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic reg_acc(input logic wr, input logic [7:0] ofs, input logic [31:0] d);
      @(negedge clk_sys);
      reg_write = wr;
      reg_read = !wr;
      reg_offset = ofs;
      reg_byte_en = 4'hF;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_write = 1'b0;
      reg_read = 1'b0;
   endtask

   // Traces strobes, selects, drive enable, done and retry for 32 cycles; cycle 0 carries the start pulse
   task automatic xfer(input logic wr, input logic [15:0] a, input logic [3:0] be);
      for (int k = 0; k < 32; k++) begin
         @(negedge clk_sys);
         tr[0][k] = &periph_chip_selects_n;
         tr[1][k] = periph_read_strobe_n;
         tr[2][k] = periph_write_strobe_n;
         tr[3][k] = periph_read_not_write_n;
         tr[4][k] = &periph_data_strobes_n;
         tr[5][k] = periph_data_oe;
         tr[6][k] = ~txn_done;
         tr[7][k] = ~txn_retry;
         if (k == 2) begin
            cs_at2 = periph_chip_selects_n;
            ds_at2 = periph_data_strobes_n;
         end
         txn_start = (k == 0);
         txn_write = wr;
         txn_addr = a;
         txn_byte_en = be;
         txn_wdata = 8'h3C;
      end
   endtask

   function automatic int first(input logic [31:0] t, input logic v, input int from);
      for (int k = from; k < 32; k++) begin
         if (t[k] === v) return k;
      end
      return 99;
   endfunction

   task automatic pulse_chk(input int i, input int f, input int r);
      check(first(tr[i], 1'b0, 0), f);
      check(first(tr[i], 1'b1, f), r);
   endtask

   task automatic s_registers();
      reg_acc(1'b0, lbt_pkg::OFS_T1, 32'h0000_0000);
      check(reg_rdata, 32'h2030_2030);
      reg_acc(1'b0, lbt_pkg::OFS_T2, 32'h0000_0000);
      check(reg_rdata, 32'h00C0_04F0);
      check(bar0_size_code, 3'b100);
      reg_acc(1'b0, 8'h10, 32'h0000_0000);
      check(reg_rdata, 32'h0000_0000);
      reg_acc(1'b1, lbt_pkg::OFS_T2, 32'hFFFF_FFFF);
      reg_acc(1'b0, lbt_pkg::OFS_T2, 32'h0000_0000);
      check(reg_rdata, 32'h87C0_FFFF);
      reg_acc(1'b1, lbt_pkg::OFS_T2, 32'h00C0_04F0);
   endtask

   task automatic s_default_cycles();
      xfer(1'b1, 16'h0010, 4'h1);
      pulse_chk(0, 2, 4);
      pulse_chk(2, 2, 4);
      check(first(tr[5], 1'b0, 0), 99);
      check(first(tr[6], 1'b0, 0), 5);
      check(cs_at2, 4'b1011);
      check(periph_addr, 16'h0010);
      check(periph_data_out, 8'h3C);
      xfer(1'b0, 16'h0000, 4'h1);
      pulse_chk(1, 2, 5);
      pulse_chk(5, 2, 6);
      check(first(tr[6], 1'b0, 0), 7);
      check(txn_rdata, 8'h5A);
   endtask

   task automatic s_programmed_cycles();
      reg_acc(1'b1, lbt_pkg::OFS_T1, 32'h7361_5030);
      reg_acc(1'b1, lbt_pkg::OFS_T2, 32'h0080_0082);
      xfer(1'b1, 16'h0000, 4'h1);
      pulse_chk(0, 2, 7);
      pulse_chk(2, 5, 9);
      check(first(tr[5], 1'b1, 0), 4);
      check(first(tr[5], 1'b0, 4), 10);
      check(first(tr[6], 1'b0, 0), 11);
      read_word = 8'hC3;
      xfer(1'b0, 16'h0000, 4'h1);
      pulse_chk(1, 3, 8);
      check(first(tr[5], 1'b1, 0), 99);
      check(txn_rdata, 8'hC3);
   endtask

   task automatic s_strobe_mode();
      reg_acc(1'b1, lbt_pkg::OFS_T1, 32'h2030_2030);
      reg_acc(1'b1, lbt_pkg::OFS_T2, 32'h8080_04F0);
      xfer(1'b1, 16'h0000, 4'b0101);
      pulse_chk(3, 2, 4);
      pulse_chk(4, 2, 4);
      check(ds_at2, 4'b1010);
      check(first(tr[2], 1'b0, 0), 99);
      read_word = 8'h96;
      xfer(1'b0, 16'h0000, 4'b1111);
      pulse_chk(4, 2, 5);
      check(first(tr[3], 1'b0, 0), 99);
      check(txn_rdata, 8'h96);
   endtask

   task automatic s_retry_and_strap();
      reg_acc(1'b1, lbt_pkg::OFS_T1, 32'hB030_2030);
      xfer(1'b1, 16'h0000, 4'h1);
      check(first(tr[7], 1'b0, 0), 1);
      check(first(tr[0], 1'b0, 0), 99);
      @(negedge clk_sys);
      reset = 1'b1;
      par_port_strap = 1'b1;
      repeat (3) @(negedge clk_sys);
      reset = 1'b0;
      reg_acc(1'b0, lbt_pkg::OFS_T1, 32'h0000_0000);
      check(reg_rdata, 32'h2121_2020);
      check(bar0_size_code, 3'b010);
      reg_acc(1'b1, lbt_pkg::OFS_T2, 32'h8120_02F0);
      reg_acc(1'b0, lbt_pkg::OFS_T2, 32'h0000_0000);
      check(reg_rdata, 32'h0120_02F0);
   endtask

   initial begin
      repeat (3) @(negedge clk_sys);
      reset = 1'b0;
      s_registers();
      s_default_cycles();
      s_programmed_cycles();
      s_strobe_mode();
      s_retry_and_strap();
      end_of_test();
   end
endmodule // test_local_bus_strobe_timing
